// file: rtl/data_space_address_decoder.sv
// Data-space address decoder and access sequencer.
// Assumes the CPU holds a request until done pulses and keeps the
// working register file; this block reads and updates pointer pairs.
//
// Functional notes
// - Normal map: 32 registers, 64 I/O, 160 extended I/O, 4096 SRAM.
// - Legacy map: 32 registers, 64 I/O, then 4000 SRAM bytes.
// - Legacy map has no extended I/O; those addresses are SRAM.
// - Extended I/O 0x60..0xFF only via load and store, not short I/O.
// - External SRAM runs from past internal SRAM up to 64K top.
// - Addresses above internal memory go to external SRAM interface.
// - External strobes stay inactive during internal memory accesses.
// - External interface driven only when external enable is set.
// - No wait states: external byte costs one extra cycle.
// - External stack, no waits: call, return, interrupt add three cycles.
// - One to three waits: byte access adds two, three or four cycles.
// - One to three waits: stack transfers add five, seven, nine cycles.
// - Internal data SRAM access completes in two clock cycles.
// - Displacement mode adds up to 63 to second or third pointer; the code also adds it to the first pointer (26/27).
// - Pre-decrement before access, post-increment after access.
// - Direct addressing reaches every location of the data space.
// - Pointers are register pairs 26/27, 28/29, 30/31, 16 bits each.
`timescale 1ns/1ps
module data_space_address_decoder
  import dsd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Configuration
  input  wire logic        legacy_mode,
  input  wire logic        external_memory_enable,
  input  wire logic [1:0]  wait_states,
  // CPU request
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic        io_path,
  input  wire logic        stack_pair,
  input  wire addr_mode_t  mode,
  input  wire logic [15:0] direct_addr,
  input  wire logic [1:0]  ptr_sel,
  input  wire logic [5:0]  disp,
  input  wire logic [15:0] ptr_value,
  input  wire logic [7:0]  wdata,
  // CPU answer
  output logic             done,
  output logic             busy,
  output logic             refused,
  output logic [15:0]      addr_out,
  output logic [2:0]       region_out,
  output logic             ptr_wr,
  output logic [4:0]       ptr_reg,
  output logic [15:0]      ptr_new,
  // External SRAM interface
  output logic [15:0]      ext_addr,
  output logic [7:0]       ext_wdata,
  output logic             ext_data_oe,
  output logic             external_strobe_pin_a_n,
  output logic             external_strobe_pin_b_n
);

  // ==========================================================
  // Address formation
  logic [15:0] eff_addr;
  logic [4:0]  sel_reg;
  region_t     region;
  logic        dec_refused;

  // Pick the pointer pair and form the access address.
  always_comb begin
    unique case (ptr_sel)
      2'd0:    sel_reg = PTR_X_LO;
      2'd1:    sel_reg = PTR_Y_LO;
      default: sel_reg = PTR_Z_LO;
    endcase
    unique case (mode)
      MODE_DIRECT: eff_addr = direct_addr;
      MODE_DISP:   eff_addr = 16'(ptr_value +
                              {10'h000, disp & DISP_MAX});
      MODE_PREDEC: eff_addr = 16'(ptr_value - 16'h0001);
      default:     eff_addr = ptr_value;
    endcase
  end

  region_decode u_dec (
    .addr        (eff_addr),
    .legacy_mode (legacy_mode),
    .io_path     (io_path),
    .region      (region),
    .refused     (dec_refused)
  );

  // ==========================================================
  // Access sequencer
  acc_state_t  state_reg, state_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic        done_reg, done_next;
  logic        ref_reg, ref_next;
  logic [15:0] addr_reg, addr_next;
  logic [2:0]  reg_reg, reg_next;
  logic        pw_reg, pw_next;
  logic [4:0]  pr_reg, pr_next;
  logic [15:0] pn_reg, pn_next;
  logic        ext_reg, ext_next;
  logic        rd_n_reg, rd_n_next;
  logic        wr_n_reg, wr_n_next;
  logic        oe_reg, oe_next;
  logic [7:0]  wd_reg, wd_next;
  logic        busy_reg, busy_next;
  logic [15:0] xa_reg, xa_next;
  logic        ext_go;

  assign ext_go = (region == REGION_XSRAM) && external_memory_enable;

  // Compute the next sequencer state and outputs.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    done_next  = 1'b0;
    ref_next   = 1'b0;
    addr_next  = addr_reg;
    reg_next   = reg_reg;
    pw_next    = 1'b0;
    pr_next    = pr_reg;
    pn_next    = pn_reg;
    ext_next   = ext_reg;
    rd_n_next  = 1'b1;
    wr_n_next  = 1'b1;
    oe_next    = 1'b0;
    wd_next    = wd_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (req && !done_reg) begin
          addr_next = eff_addr;
          reg_next  = region;
          pr_next   = sel_reg;
          if (mode == MODE_PREDEC) begin
            pn_next = eff_addr;
          end else begin
            pn_next = 16'(ptr_value + 16'h0001);
          end
          if (dec_refused) begin
            done_next = 1'b1;
            ref_next  = 1'b1;
          end else if (ext_go) begin
            state_next = ST_EXT;
            ext_next   = 1'b1;
            wd_next    = wdata;
            // Base two cycles plus the extra for this wait count.
            cnt_next   = 4'(INT_ACCESS_CYC - 4'd1 +
                         (stack_pair ? stack_extra(wait_states)
                                     : ext_extra(wait_states)));
            rd_n_next  = we;
            wr_n_next  = !we;
            oe_next    = we;
          end else begin
            state_next = ST_INT;
            cnt_next   = 4'(INT_ACCESS_CYC - 4'd1);
          end
        end
      end
      ST_INT: begin
        // Strobes stay high through the whole internal access.
        cnt_next = 4'(cnt_reg - 4'd1);
        if (cnt_reg == 4'd1) begin
          done_next  = 1'b1;
          state_next = ST_IDLE;
          pw_next    = (mode != MODE_DIRECT) && (mode != MODE_DISP);
        end
      end
      ST_EXT: begin
        cnt_next = 4'(cnt_reg - 4'd1);
        if (cnt_reg == 4'd1) begin
          done_next  = 1'b1;
          state_next = ST_IDLE;
          ext_next   = 1'b0;
          pw_next    = (mode != MODE_DIRECT) && (mode != MODE_DISP);
        end else begin
          rd_n_next = rd_n_reg;
          wr_n_next = wr_n_reg;
          oe_next   = oe_reg;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Busy and the external address are registered so the pins
    // come straight from flip-flops, not from a decode of state.
    busy_next = (state_next != ST_IDLE);
    xa_next   = ext_next ? addr_next : 16'h0000;
  end

  // Register the sequencer.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 4'h0;
      done_reg  <= 1'b0;
      ref_reg   <= 1'b0;
      addr_reg  <= 16'h0000;
      reg_reg   <= 3'h0;
      pw_reg    <= 1'b0;
      pr_reg    <= 5'h00;
      pn_reg    <= 16'h0000;
      ext_reg   <= 1'b0;
      rd_n_reg  <= 1'b1;
      wr_n_reg  <= 1'b1;
      oe_reg    <= 1'b0;
      wd_reg    <= 8'h00;
      busy_reg  <= 1'b0;
      xa_reg    <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      done_reg  <= done_next;
      ref_reg   <= ref_next;
      addr_reg  <= addr_next;
      reg_reg   <= reg_next;
      pw_reg    <= pw_next;
      pr_reg    <= pr_next;
      pn_reg    <= pn_next;
      ext_reg   <= ext_next;
      rd_n_reg  <= rd_n_next;
      wr_n_reg  <= wr_n_next;
      oe_reg    <= oe_next;
      wd_reg    <= wd_next;
      busy_reg  <= busy_next;
      xa_reg    <= xa_next;
    end
  end

  // ==========================================================
  // Outputs, each straight from a flip-flop.
  assign done       = done_reg;
  assign busy       = busy_reg;
  assign refused    = ref_reg;
  assign addr_out   = addr_reg;
  assign region_out = reg_reg;
  assign ptr_wr     = pw_reg;
  assign ptr_reg    = pr_reg;
  assign ptr_new    = pn_reg;
  assign ext_addr   = xa_reg;
  assign ext_wdata  = wd_reg;
  assign ext_data_oe = oe_reg;
  assign external_strobe_pin_a_n = wr_n_reg;
  assign external_strobe_pin_b_n = rd_n_reg;

  // ==========================================================
  // Checks
  int unsigned len_cnt;
  always_ff @(posedge clk) begin
    if (!rst_n || state_reg == ST_IDLE) begin
      len_cnt <= 0;
    end else begin
      len_cnt <= len_cnt + 1;
    end
  end

  int_strobes_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_INT |-> wr_n_reg && rd_n_reg)
    else $error("strobe active during internal access");

  int_two_cyc_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_IDLE && state_next == ST_INT |=> ##1 done_reg)
    else $error("internal access not two cycles");

  ext_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_IDLE && req && !done_reg && !external_memory_enable
      |=> wr_n_reg && rd_n_reg && !oe_reg)
    else $error("external interface driven while disabled");

  ext_nowait_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_IDLE && state_next == ST_EXT && wait_states == 2'd0
      && !stack_pair |=> ##2 done_reg)
    else $error("external byte not three cycles");

  // Cycles spent busy are the whole access less one: wait count plus two.
  ext_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(done_reg) && $past(state_reg) == ST_EXT && !stack_pair
      && wait_states != 2'd0
      |-> len_cnt == 32'(wait_states) + 32'd2)
    else $error("external wait access length wrong");

  stack_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ST_IDLE && state_next == ST_EXT && stack_pair
      |=> cnt_reg == 4'(4'd4 + {wait_states, 1'b0}))
    else $error("stack transfer length wrong");

  legacy_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    legacy_mode && eff_addr >= EXTIO_BASE && eff_addr < LEG_SRAM_END
      |-> region == REGION_ISRAM)
    else $error("legacy map decode wrong");

  io_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
    region == REGION_EXTIO && io_path && req && state_reg == ST_IDLE
      && !done_reg |=> done_reg && ref_reg)
    else $error("extended io reached by short path");

  xsram_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    !legacy_mode && eff_addr >= NORM_SRAM_END
      |-> region == REGION_XSRAM)
    else $error("external region decode wrong");

endmodule : data_space_address_decoder

// file: rtl/dsd_pkg.sv
// Package for the data-space address decoder.
// Assumes a 16-bit data address space and an 8-bit data path.
package dsd_pkg;

  // ==========================================================
  // Data map
  localparam logic [15:0] REG_BASE      = 16'h0000;
  localparam logic [15:0] STDIO_BASE    = 16'h0020;
  localparam logic [15:0] EXTIO_BASE    = 16'h0060;
  localparam logic [15:0] EXTIO_LAST    = 16'h00FF;
  localparam logic [15:0] NORM_SRAM_BASE = 16'h0100;
  localparam logic [15:0] NORM_SRAM_END  = 16'h1100;  // 256 + 4096
  localparam logic [15:0] LEG_SRAM_BASE  = 16'h0060;
  localparam logic [15:0] LEG_SRAM_END   = 16'h1000;  // 96 + 4000

  // ==========================================================
  // Pointer registers live in working registers 26..31.
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;
  localparam logic [5:0] DISP_MAX = 6'h3F;

  // ==========================================================
  // Timing counts in CPU cycles.
  localparam logic [3:0] INT_ACCESS_CYC = 4'h2;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    REGION_REG   = 3'h0,
    REGION_STDIO = 3'h1,
    REGION_EXTIO = 3'h2,
    REGION_ISRAM = 3'h3,
    REGION_XSRAM = 3'h4
  } region_t;

  typedef enum logic [1:0] {
    MODE_DIRECT = 2'h0,
    MODE_DISP   = 2'h1,
    MODE_PREDEC = 2'h2,
    MODE_POSTINC = 2'h3
  } addr_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INT  = 2'b01,
    ST_EXT  = 2'b11
  } acc_state_t;

  // Extra cycles for a single byte external access per wait count.
  function automatic logic [3:0] ext_extra(input logic [1:0] ws);
    ext_extra = (ws == 2'd0) ? 4'd1 : 4'({2'b00, ws} + 4'd1);
  endfunction : ext_extra

  // Extra cycles for a two-byte stack transfer per wait count.
  function automatic logic [3:0] stack_extra(input logic [1:0] ws);
    stack_extra = 4'(4'd3 + {ws, 1'b0});
  endfunction : stack_extra

endpackage : dsd_pkg

// file: rtl/region_decode.sv
// Region decoder for a 16-bit data address.
// Assumes purely combinational use by the access sequencer.
`timescale 1ns/1ps
module region_decode
  import dsd_pkg::*;
(
  // Address in
  input  wire logic [15:0] addr,
  input  wire logic        legacy_mode,
  input  wire logic        io_path,
  // Decode out
  output region_t          region,
  output logic             refused
);

  // ==========================================================
  // Decode
  // Extended I/O only exists in normal mode and never on the short path.
  always_comb begin
    refused = 1'b0;
    if (addr < STDIO_BASE) begin
      region = REGION_REG;
    end else if (addr < EXTIO_BASE) begin
      region = REGION_STDIO;
    end else if (!legacy_mode && addr <= EXTIO_LAST) begin
      region  = REGION_EXTIO;
      refused = io_path;
    end else if (!legacy_mode && addr < NORM_SRAM_END) begin
      region = REGION_ISRAM;
    end else if (legacy_mode && addr < LEG_SRAM_END) begin
      region = REGION_ISRAM;
    end else begin
      region = REGION_XSRAM;
    end
  end

endmodule : region_decode

// file: test/xsram_model.sv
// External SRAM model that sits on the decoder's memory bus.
// Assumes active-low strobes, with strobe a for writes and b for reads.
`timescale 1ns/1ps
module xsram_model (
  // Clock
  input wire logic        clk,
  // Memory bus
  input wire logic        wr_n,
  input wire logic        rd_n,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        oe
);
  // ==========================================================
  // Storage
  logic [7:0] mem [int];

  // A byte is stored on each edge that sees the write strobe with data.
  always @(posedge clk) begin
    if (wr_n === 1'b0 && oe === 1'b1) begin
      mem[addr] = wdata;
    end
  end
endmodule : xsram_model

// file: test/tb_data_space_address_decoder.sv
// Self-checking bench for the data-space address decoder.
// Assumes the external SRAM model keeps every byte it is sent.
`timescale 1ns/1ps
module tb_data_space_address_decoder;
  import dsd_pkg::*;
  logic clk = 0, rst_n = 0, lg = 0, en = 1, req = 0, we = 0, io = 0;
  logic stk = 0;
  logic [1:0] ws = 0, ps = 0;
  addr_mode_t mode = MODE_DIRECT;
  logic [15:0] da = 0, pv = 0;
  logic [5:0] dp = 0;
  logic [7:0] wd = 0;
  logic done, busy, rf, pw, oe, sa_n, sb_n;
  logic [15:0] ao, pn, xa;
  logic [2:0] ro;
  logic [4:0] pr;
  logic [7:0] xd;
  int failures = 0, num_checks = 0, cyc = 0;

  data_space_address_decoder dut (.clk(clk), .rst_n(rst_n),
    .legacy_mode(lg), .external_memory_enable(en), .wait_states(ws),
    .req(req), .we(we), .io_path(io), .stack_pair(stk), .mode(mode),
    .direct_addr(da), .ptr_sel(ps), .disp(dp), .ptr_value(pv),
    .wdata(wd), .done(done), .busy(busy), .refused(rf), .addr_out(ao),
    .region_out(ro), .ptr_wr(pw), .ptr_reg(pr), .ptr_new(pn),
    .ext_addr(xa), .ext_wdata(xd), .ext_data_oe(oe),
    .external_strobe_pin_a_n(sa_n), .external_strobe_pin_b_n(sb_n));
  xsram_model mem_i (.clk(clk), .wr_n(sa_n), .rd_n(sb_n), .addr(xa),
    .wdata(xd), .oe(oe));

  // The clock toggles every 20 ns, half of its 40 ns period.
  always #20 clk = ~clk;

  // A hang is cut short by a cycle ceiling.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      wrap_up();
    end
  end

  // ==========================================================
  // Checking and closing
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // One access, compared with the reference model of the map.
  task automatic acc(logic w, logic i, logic s, addr_mode_t m,
                     logic [15:0] a, logic [1:0] p, logic [5:0] d,
                     logic [15:0] v, logic [7:0] b);
    int ea, rg, n, na, nb, no, lat, x, nbz, nx;
    logic r;
    // Wait one edge first so that configuration changes have landed.
    @(posedge clk);
    case (m)
      MODE_DIRECT: ea = a;
      MODE_DISP:   ea = (v + d) & 16'hFFFF;
      MODE_PREDEC: ea = (v - 1) & 16'hFFFF;
      default:     ea = v;
    endcase
    rg = ea < 'h20 ? 0 : ea < 'h60 ? 1 : lg ? (ea < 'h1000 ? 3 : 4)
       : ea < 'h100 ? 2 : ea < 'h1100 ? 3 : 4;
    r = i && !lg && rg == 2;
    x = rg == 4 && en;
    lat = r ? 1 : x ? 2 + (s ? 3 + 2 * ws : ws + 1) : 2;
    n = 0; na = 0; nb = 0; no = 0; nbz = 0; nx = 0;
    req <= 1; we <= w; io <= i; stk <= s; mode <= m;
    da <= a; ps <= p; dp <= d; pv <= v; wd <= b;
    do begin
      @(posedge clk);
      #1 n++;
      if (!done) begin
        na += (sa_n !== 1'b1);
        nb += (sb_n !== 1'b1);
        no += (oe !== 1'b0);
        nbz += (busy === 1'b1);
        nx += (xa !== (x ? 16'(ea) : 16'h0000));
      end
    end while (done !== 1'b1 && n < 40);
    chk("latency", n, lat);
    chk("busy", nbz, lat - 1);
    chk("ext addr", nx, 0);
    chk("refused", rf, r);
    chk("region", ro, rg);
    chk("addr", ao, ea);
    chk("wr strobe", na, x && w && !r ? lat - 1 : 0);
    chk("rd strobe", nb, x && !w && !r ? lat - 1 : 0);
    chk("data oe", no, x && w && !r ? lat - 1 : 0);
    if (!r) begin
      chk("ptr wr", pw, m == MODE_PREDEC || m == MODE_POSTINC);
    end
    if (!r && (m == MODE_PREDEC || m == MODE_POSTINC)) begin
      chk("ptr reg", pr, p == 0 ? 26 : p == 1 ? 28 : 30);
      chk("ptr new", pn, m == MODE_PREDEC ? ea : (v + 1) & 'hFFFF);
    end
    if (x && w && !r) begin
      chk("ext byte", mem_i.mem[ea], b);
    end
    @(posedge clk);
    req <= 0;
    #1 chk("done width", done, 1'b0);
  endtask : acc

  // ==========================================================
  // Main sequence
  logic [15:0] edges [11] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060,
    16'h00FF, 16'h0100, 16'h0FFF, 16'h1000, 16'h10FF, 16'h1100,
    16'hFFFF};
  initial begin
    void'($urandom(32'hf27c));
    repeat (5) @(posedge clk);
    rst_n <= 1;
    // Region edges in both maps, loads and stores.
    for (int k = 0; k < 4; k++) begin
      lg <= k[1];
      foreach (edges[j]) acc(k[0], 0, 0, MODE_DIRECT, edges[j], 0, 0,
                             0, 8'h5A + 8'(j));
    end
    $display("test map edges done");
    // Short-form path to extended I/O in both maps.
    for (int k = 0; k < 4; k++) begin
      lg <= k[1];
      acc(0, 1, 0, MODE_DIRECT, k[0] ? 16'h00FF : 16'h0060, 0, 0, 0,
          0);
    end
    lg <= 0;
    $display("test short io done");
    // Every wait count, single bytes and stack pairs.
    for (int k = 0; k < 16; k++) begin
      ws <= k[1:0];
      acc(k[2], 0, k[3], MODE_DIRECT, 16'h2000 + 16'(k), 0, 0, 0,
          8'(k));
    end
    $display("test wait states done");
    // External region with the interface disabled.
    en <= 0;
    acc(1, 0, 0, MODE_DIRECT, 16'h8000, 0, 0, 0, 8'hC3);
    acc(0, 0, 0, MODE_DIRECT, 16'h1100, 0, 0, 0, 0);
    en <= 1;
    $display("test disabled interface done");
    // Pointer modes at wrap points and the largest displacement.
    acc(0, 0, 0, MODE_PREDEC, 0, 0, 0, 16'h0000, 0);
    acc(1, 0, 0, MODE_POSTINC, 0, 3, 0, 16'hFFFF, 8'h11);
    acc(0, 0, 0, MODE_DISP, 0, 1, 6'h3F, 16'h10C1, 0);
    acc(1, 0, 0, MODE_DISP, 0, 2, 6'h3F, 16'h00C1, 8'h22);
    $display("test pointer modes done");
    // Random mix of accesses.
    for (int k = 0; k < 60; k++) begin
      lg <= $urandom % 2;
      ws <= $urandom % 4;
      en <= ($urandom % 4) != 0;
      acc($urandom % 2, $urandom % 2, 0, addr_mode_t'($urandom % 4),
          $urandom, $urandom % 4, $urandom, $urandom, $urandom);
    end
    $display("test random done");
    wrap_up();
  end
endmodule : tb_data_space_address_decoder
